//--- design/inband_loop_code_gen_detect.sv
// in-band loop code generator, three detectors and apb register file
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module inband_loop_code_gen_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_en,
  input wire logic tx_data_in,
  input wire logic tx_fbit_slot,
  input wire logic rx_bit,
  output logic tx_data_out
);
  typedef struct packed {
    logic [7:0] tx_code_def_first;
    logic [7:0] tx_code_def_second;
    logic [7:0] inband_code_control;
    logic [7:0] ccr1;
    logic [7:0] up1;
    logic [7:0] up2;
    logic [7:0] dn1;
    logic [7:0] dn2;
    logic [7:0] sp1;
    logic [7:0] sp2;
    logic [7:0] scc;
    logic [7:0] mode;
    logic [3:0] tx_pos;
    logic tx_out;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } top_state_t;
  top_state_t s_r;
  top_state_t s_nxt;
  logic t1_mode;
  logic [2:0] det_hit;
  logic [15:0] tx_code;
  logic [4:0] tx_len;
  logic [2:0] up_len;
  logic [2:0] dn_len;
  logic [2:0] sp_len;

  // detector length code: 0..6 give 1..7 bits, 7 gives 16 bits; 8-bit detection uses code 7 on a 16-bit pair
  function automatic logic [15:0] len_mask(input logic [2:0] l);
    logic [15:0] m;
    m = 16'hFFFF;
    if (l != 3'd7)
      m = ~(16'hFFFF >> ({1'b0, l} + 4'd1));
    return m;
  endfunction

  // tx length: 00 = 5, 01 = 6, 10 = 7, 11 = 16; other lengths repeat inside a 16-bit pair
  function automatic logic [4:0] tx_len_of(input logic [1:0] sel);
    logic [4:0] n;
    unique case (sel)
      2'b00: n = 5'd5;
      2'b01: n = 5'd6;
      2'b10: n = 5'd7;
      2'b11: n = 5'd16;
    endcase
    return n;
  endfunction

  assign t1_mode = s_r.mode[loop_code_pkg::t1_mode_pos];
  assign tx_code = {s_r.tx_code_def_first, s_r.tx_code_def_second};
  assign tx_len = tx_len_of({s_r.inband_code_control[loop_code_pkg::tx_len_sel_hi_pos], s_r.inband_code_control[loop_code_pkg::tx_len_sel_lo_pos]});
  // up/down from control, spare from own
  assign up_len = s_r.inband_code_control[loop_code_pkg::up_len_pos +: 3];
  assign dn_len = s_r.inband_code_control[loop_code_pkg::down_len_pos +: 3];
  assign sp_len = s_r.scc[2:0];

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ready = 1'b0;
    s_nxt.err = 1'b0;
    if (psel && !penable)
    begin
      s_nxt.ready = 1'b1;
      s_nxt.rdata = '0;
      unique case (paddr)
        loop_code_pkg::tx_code_def_first_off: s_nxt.rdata[7:0] = s_r.tx_code_def_first;
        loop_code_pkg::tx_code_def_second_off: s_nxt.rdata[7:0] = s_r.tx_code_def_second;
        loop_code_pkg::inband_code_control_off: s_nxt.rdata[7:0] = s_r.inband_code_control;
        loop_code_pkg::t1_common_control_one_off: s_nxt.rdata[7:0] = s_r.ccr1;
        loop_code_pkg::rx_up_code_first_off: s_nxt.rdata[7:0] = s_r.up1;
        loop_code_pkg::rx_up_code_second_off: s_nxt.rdata[7:0] = s_r.up2;
        loop_code_pkg::rx_down_code_first_off: s_nxt.rdata[7:0] = s_r.dn1;
        loop_code_pkg::rx_down_code_second_off: s_nxt.rdata[7:0] = s_r.dn2;
        loop_code_pkg::rx_spare_code_first_off: s_nxt.rdata[7:0] = s_r.sp1;
        loop_code_pkg::rx_spare_code_second_off: s_nxt.rdata[7:0] = s_r.sp2;
        loop_code_pkg::rx_spare_code_control_off: s_nxt.rdata[7:0] = s_r.scc;
        loop_code_pkg::mode_control_off: s_nxt.rdata[7:0] = s_r.mode;
        loop_code_pkg::status_three_off: s_nxt.rdata[7:5] = det_hit;
        default: s_nxt.err = 1'b1;
      endcase
      if (pwrite)
        s_nxt.rdata = '0;
    end
    // a write lands at the edge where the master samples pready high, not at setup
    if (psel && penable && pwrite && s_r.ready)
    begin
      unique case (paddr)
        loop_code_pkg::tx_code_def_first_off: s_nxt.tx_code_def_first = pwdata[7:0];
        loop_code_pkg::tx_code_def_second_off: s_nxt.tx_code_def_second = pwdata[7:0];
        loop_code_pkg::inband_code_control_off: s_nxt.inband_code_control = pwdata[7:0];
        loop_code_pkg::t1_common_control_one_off: s_nxt.ccr1 = pwdata[7:0];
        loop_code_pkg::rx_up_code_first_off: s_nxt.up1 = pwdata[7:0];
        loop_code_pkg::rx_up_code_second_off: s_nxt.up2 = pwdata[7:0];
        loop_code_pkg::rx_down_code_first_off: s_nxt.dn1 = pwdata[7:0];
        loop_code_pkg::rx_down_code_second_off: s_nxt.dn2 = pwdata[7:0];
        loop_code_pkg::rx_spare_code_first_off: s_nxt.sp1 = pwdata[7:0];
        loop_code_pkg::rx_spare_code_second_off: s_nxt.sp2 = pwdata[7:0];
        loop_code_pkg::rx_spare_code_control_off: s_nxt.scc = pwdata[7:0];
        loop_code_pkg::mode_control_off: s_nxt.mode = pwdata[7:0];
        loop_code_pkg::status_three_off: s_nxt.err = 1'b0;
        // unmapped writes were already refused with pslverr, decoded in the setup cycle and raised with pready in the next
        default: s_nxt.err = 1'b0;
      endcase
    end
    if (bit_en)
    begin
      // the framer marks the f-bit slot itself, so no local frame count is kept
      s_nxt.tx_out = tx_data_in;
      if (t1_mode && s_r.ccr1[loop_code_pkg::tx_loop_code_enable_pos])
      begin
        // 80h with length 00 gives 10000
        s_nxt.tx_out = tx_code[4'd15 - s_r.tx_pos];
        s_nxt.tx_pos = (5'(s_r.tx_pos) + 5'd1 >= tx_len) ? 4'h0 : s_r.tx_pos + 4'h1;
        if (tx_fbit_slot && !s_r.mode[loop_code_pkg::no_fbit_insert_pos])
          s_nxt.tx_out = tx_data_in;
      end
      else
        s_nxt.tx_pos = 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
    end
    else
      s_r <= s_nxt;
  end

  // up to four compare errors per 48-bit window tolerated
  loop_code_detector u_up (
    .pclk(pclk), .presetn(presetn), .bit_en(bit_en), .rx_bit(rx_bit),
    .code({s_r.up1, s_r.up2}), .len_sel(up_len), .sel_len_mask(len_mask(up_len)),
    .enable(t1_mode), .detected(det_hit[0])
  );
  loop_code_detector u_dn (
    .pclk(pclk), .presetn(presetn), .bit_en(bit_en), .rx_bit(rx_bit),
    .code({s_r.dn1, s_r.dn2}), .len_sel(dn_len), .sel_len_mask(len_mask(dn_len)),
    .enable(t1_mode), .detected(det_hit[1])
  );
  loop_code_detector u_sp (
    .pclk(pclk), .presetn(presetn), .bit_en(bit_en), .rx_bit(rx_bit),
    .code({s_r.sp1, s_r.sp2}), .len_sel(sp_len), .sel_len_mask(len_mask(sp_len)),
    .enable(t1_mode), .detected(det_hit[2])
  );

  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign tx_data_out = s_r.tx_out;
endmodule
`default_nettype wire

//--- design/loop_code_pkg.sv
// constants for the in-band loop code generator and detectors
package loop_code_pkg;
  // register byte offsets on apb
  localparam logic [7:0] tx_code_def_first_off = 8'h00;
  localparam logic [7:0] tx_code_def_second_off = 8'h04;
  localparam logic [7:0] inband_code_control_off = 8'h08;
  localparam logic [7:0] t1_common_control_one_off = 8'h0C;
  localparam logic [7:0] rx_up_code_first_off = 8'h10;
  localparam logic [7:0] rx_up_code_second_off = 8'h14;
  localparam logic [7:0] rx_down_code_first_off = 8'h18;
  localparam logic [7:0] rx_down_code_second_off = 8'h1C;
  localparam logic [7:0] rx_spare_code_first_off = 8'h20;
  localparam logic [7:0] rx_spare_code_second_off = 8'h24;
  localparam logic [7:0] rx_spare_code_control_off = 8'h28;
  localparam logic [7:0] status_three_off = 8'h2C;
  localparam logic [7:0] mode_control_off = 8'h30;
  // field positions
  localparam int tx_len_sel_lo_pos = 6;
  localparam int tx_len_sel_hi_pos = 7;
  localparam int up_len_pos = 0;
  localparam int down_len_pos = 3;
  localparam int tx_loop_code_enable_pos = 0;
  localparam int t1_mode_pos = 0;
  localparam int no_fbit_insert_pos = 1;
  localparam int loop_up_detected_pos = 5;
  localparam int loop_down_detected_pos = 6;
  localparam int spare_code_detected_pos = 7;
  // reset values
  localparam logic [7:0] code_rst = 8'h00;
  localparam logic [7:0] ctrl_rst = 8'h00;
  // frame length in bits
  localparam int frame_bits = 193;
  // detector window: 48 bits sampled, error tolerance count
  localparam int det_window = 48;
  localparam int det_max_err = 4;
endpackage

//--- design/loop_code_detector.sv
// one repeating-code detector with error-tolerant windowed compare
`timescale 1ns/1ns
`default_nettype none
module loop_code_detector #(
  parameter int window = loop_code_pkg::det_window,
  parameter int max_err = loop_code_pkg::det_max_err
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bit_en,
  input wire logic rx_bit,
  input wire logic [15:0] code,
  input wire logic [2:0] len_sel,
  input wire logic [15:0] sel_len_mask,
  input wire logic enable,
  output logic detected
);
  typedef struct packed {
    logic [15:0] hist;
    logic [5:0] pos;
    logic [5:0] errs;
    logic [4:0] miss;
    logic hit;
  } det_state_t;
  det_state_t s_r;
  det_state_t s_nxt;
  logic [4:0] len;
  logic rot_hit;

  // true when the newest len bits are any rotation of the code, so a hit does not hang on pattern phase
  function automatic logic rotation_match(input logic [15:0] h, input logic [15:0] c, input logic [4:0] n);
    logic any;
    logic ok;
    any = 1'b0;
    for (int p = 0; p < 16; p++)
    begin
      ok = (p < int'(n));
      for (int j = 0; j < 16; j++)
      begin
        if (j < int'(n) && h[j] != c[15 - ((p >= j) ? (p - j) : (p - j + int'(n)))])
          ok = 1'b0;
      end
      any = any | ok;
    end
    return any;
  endfunction

  // length code 0..6 gives 1..7 bits; only code 7 has an all-ones mask and means sixteen
  assign len = (&sel_len_mask) ? 5'd16 : {2'b00, len_sel} + 5'd1;
  assign rot_hit = rotation_match(s_r.hist, code, len);

  // compare against the history len bits back, so a framing bit costs at most two errors per frame, once received and once len bits later
  always_comb
  begin
    s_nxt = s_r;
    if (!enable)
    begin
      s_nxt = '0;
    end
    else if (bit_en)
    begin
      s_nxt.hist = {s_r.hist[14:0], rx_bit};
      s_nxt.pos = s_r.pos + 6'd1;
      if (rx_bit != s_r.hist[len[3:0] - 4'd1] && s_r.pos >= 6'(len))
        s_nxt.errs = s_r.errs + 6'd1;
      if (s_r.pos == 6'(window - 1))
      begin
        s_nxt.pos = '0;
        s_nxt.errs = '0;
        if (s_r.errs <= 6'(max_err) && rot_hit)
        begin
          s_nxt.hit = 1'b1;
          s_nxt.miss = '0;
        end
        // a window that fails either test counts as bad
        else
        begin
          s_nxt.miss = s_r.miss + 5'd1;
          if (s_r.miss == 5'd3)
            s_nxt.hit = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign detected = s_r.hit;
endmodule
`default_nettype wire

//--- verif/loop_code_props.sv
// port-level checks for the loop code block
`timescale 1ns/1ns
`default_nettype none
module loop_code_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_en,
  input wire logic tx_data_in,
  input wire logic tx_fbit_slot,
  input wire logic rx_bit,
  input wire logic tx_data_out
);
  logic en_r;
  logic t1_r;
  logic nofb_r;
  logic wr_hit;
  logic gen_on;
  assign wr_hit = psel && penable && pready && pwrite;
  assign gen_on = en_r && t1_r;
  // mirror only the bits that steer the transmit mux
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_r <= 1'b0;
      t1_r <= 1'b0;
      nofb_r <= 1'b0;
    end
    else if (wr_hit && paddr == loop_code_pkg::t1_common_control_one_off)
      en_r <= pwdata[loop_code_pkg::tx_loop_code_enable_pos];
    else if (wr_hit && paddr == loop_code_pkg::mode_control_off)
    begin
      t1_r <= pwdata[loop_code_pkg::t1_mode_pos];
      nofb_r <= pwdata[loop_code_pkg::no_fbit_insert_pos];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without a setup cycle");
  a_err_paired: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  a_unmapped_err: assert property (pready && paddr > loop_code_pkg::mode_control_off |-> pslverr)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_tx_steady: assert property (!$past(bit_en) |-> $stable(tx_data_out))
    else $error("transmit bit moved without a bit strobe");
  a_tx_bypass: assert property ($past(bit_en) && !$past(gen_on) |-> tx_data_out == $past(tx_data_in))
    else $error("transmit path not passing framer data");
  a_fbit_over: assert property ($past(bit_en) && $past(tx_fbit_slot) && !$past(nofb_r)
    |-> tx_data_out == $past(tx_data_in))
    else $error("framing slot not overwritten");
endmodule
bind inband_loop_code_gen_detect loop_code_props i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .bit_en, .tx_data_in, .tx_fbit_slot, .rx_bit, .tx_data_out);
`default_nettype wire

//--- verif/t1_line_model.sv
// framer side: bit strobe, framing slot, transmit and receive bits
`timescale 1ns/1ns
`default_nettype none
module t1_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] rx_code,
  input wire logic [4:0] rx_len,
  output logic bit_en,
  output logic tx_fbit_slot,
  output logic tx_data_in,
  output logic rx_bit
);
  int pos;
  int k;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bit_en <= 1'b0;
      tx_fbit_slot <= 1'b0;
      tx_data_in <= 1'b0;
      rx_bit <= 1'b0;
      pos <= 0;
      k <= 0;
    end
    else if (!bit_en)
    begin
      bit_en <= 1'b1;
      pos <= (pos + 1) % 193;
      // wrap divides 2, 5 and 16 so the pattern phase never jumps
      k <= (k + 1) % 400;
      tx_fbit_slot <= (pos == 0);
      tx_data_in <= ~tx_data_in;
      // framing overwrite, one error per hundred
      rx_bit <= (pos == 0) ? 1'b1 : rx_code[15 - (k % rx_len)] ^ (k % 100 == 50);
    end
    else
      bit_en <= 1'b0;
  end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the loop code block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic bit_en;
  logic tx_fbit_slot;
  logic tx_data_in;
  logic rx_bit;
  logic tx_data_out;
  logic [15:0] rx_code;
  logic [4:0] rx_len;
  int miscompares;
  int tests_run;
  inband_loop_code_gen_detect i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bit_en, .tx_data_in, .tx_fbit_slot, .rx_bit, .tx_data_out);
  t1_line_model i_line (.pclk, .presetn, .rx_code, .rx_len, .bit_en, .tx_fbit_slot, .tx_data_in, .rx_bit);
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count is assumed here; only the watchdog ends a hung wait
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    if (!err)
      chk(r, exp);
    chk(32'(e), 32'(err));
  endtask
  function automatic logic rot_match(logic [31:0] v, logic [15:0] c, int l);
    logic ok;
    for (int r = 0; r < l; r++)
    begin
      ok = 1'b1;
      for (int i = 0; i < 32; i++)
        if (v[31 - i] !== c[15 - ((i + r) % l)])
          ok = 1'b0;
      if (ok)
        return 1'b1;
    end
    return 1'b0;
  endfunction
  task automatic gen_case(input logic [15:0] c, input logic [1:0] s, input int l);
    logic [31:0] v;
    wr(loop_code_pkg::tx_code_def_first_off, 32'(c[15:8]));
    wr(loop_code_pkg::tx_code_def_second_off, 32'(c[7:0]));
    wr(loop_code_pkg::inband_code_control_off, 32'({s, 6'h00}));
    // the first two bits may still carry the old length
    repeat (34)
    begin
      do @(posedge pclk); while (bit_en !== 1'b1);
      @(posedge pclk);
      v = {v[30:0], tx_data_out};
    end
    chk(32'(rot_match(v, c, l)), 32'h0000_0001);
  endtask
  task automatic pass_chk(input logic f, input int n);
    logic d;
    repeat (n)
    begin
      do @(posedge pclk); while (bit_en !== 1'b1 || (f && tx_fbit_slot !== 1'b1));
      d = tx_data_in;
      @(posedge pclk);
      chk(32'(tx_data_out), 32'(d));
    end
  endtask
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd_chk(loop_code_pkg::inband_code_control_off, 32'(loop_code_pkg::ctrl_rst), 1'b0);
    wr(loop_code_pkg::tx_code_def_first_off, 32'h0000_00a5);
    rd_chk(loop_code_pkg::tx_code_def_first_off, 32'h0000_00a5, 1'b0);
    wr(loop_code_pkg::status_three_off, 32'h0000_00e0);
    rd_chk(loop_code_pkg::status_three_off, 32'h0000_0000, 1'b0);
    rd_chk(8'h34, 32'h0000_0000, 1'b1);
  endtask
  task automatic t_gen;
    int lens[4] = '{5, 6, 7, 16};
    wr(loop_code_pkg::mode_control_off, 32'h0000_0003);
    wr(loop_code_pkg::t1_common_control_one_off, 32'h0000_0001);
    for (int s = 0; s < 4; s++)
      gen_case(16'hb15c, 2'(s), lens[s]);
    gen_case(16'h8000, 2'b00, 5);
  endtask
  task automatic t_fbit;
    wr(loop_code_pkg::mode_control_off, 32'h0000_0001);
    pass_chk(1'b1, 2);
    wr(loop_code_pkg::t1_common_control_one_off, 32'h0000_0000);
    pass_chk(1'b0, 6);
    wr(loop_code_pkg::t1_common_control_one_off, 32'h0000_0001);
    wr(loop_code_pkg::mode_control_off, 32'h0000_0000);
    pass_chk(1'b0, 6);
  endtask
  task automatic t_detect;
    logic [15:0] rc[3] = '{16'h8000, 16'hf0a6, 16'h8000};
    logic [4:0] rl[3] = '{5'd5, 5'd16, 5'd2};
    logic [31:0] exp[3] = '{32'h0000_0020, 32'h0000_0040, 32'h0000_0080};
    logic [31:0] r;
    logic e;
    int n;
    wr(loop_code_pkg::rx_up_code_first_off, 32'h0000_0080);
    wr(loop_code_pkg::rx_down_code_first_off, 32'h0000_00f0);
    wr(loop_code_pkg::rx_down_code_second_off, 32'h0000_00a6);
    wr(loop_code_pkg::rx_spare_code_first_off, 32'h0000_0080);
    wr(loop_code_pkg::rx_spare_code_control_off, 32'h0000_0001);
    wr(loop_code_pkg::inband_code_control_off, 32'h0000_003c);
    wr(loop_code_pkg::mode_control_off, 32'h0000_0001);
    for (int i = 0; i < 3; i++)
    begin
      rx_code <= rc[i];
      rx_len <= rl[i];
      n = 0;
      // poll status until the code shows
      do apb(1'b0, loop_code_pkg::status_three_off, 32'h0000_0000, r, e); while (r !== exp[i] && ++n < 400);
      chk(r, exp[i]);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rx_code = 16'h0000;
    rx_len = 5'd5;
    miscompares = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_gen();
    t_fbit();
    t_detect();
    final_report();
  end
  initial
  begin
    repeat (40000) @(posedge pclk);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
